/* File: hdl/relay_channel.sv */
/*
 One relay channel: qualification, hold timer, polarity.
 Assumes the counter result is on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module relay_channel #(
   parameter bit IMMEDIATE = 1'b0
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      ce,
   // Evaluation
   input  wire logic signed [31:0]        result,
   input  wire logic signed [31:0]        level,
   input  wire logic                      allowed,
   input  wire logic [9:0]                hold,
   input  wire logic                      unitMin,
   input  wire relay_ctrl_pkg::relay_mode_e mode,
   input  wire logic                      remoteState,
   // Output
   output logic                           closed
);
   import relay_ctrl_pkg::*;
   logic [31:0] qualCnt_reg;
   logic [31:0] tickCnt_reg;
   logic [15:0] holdCnt_reg;
   logic        atLevel, qualified, qualified_reg, active;
   logic [15:0] holdTicks;

   // ===========================================================
   // Comparison
   assign atLevel   = (result >= level) && allowed;
   assign qualified = IMMEDIATE ? atLevel : (atLevel && qualCnt_reg >= 32'(QUAL_CYCLES));
   assign holdTicks = unitMin ? 16'(hold * SEC_PER_MIN) : 16'(hold);

   // Qualification timer restarts whenever the value drops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) qualCnt_reg <= '0;
      else if (ce) begin
         if (!atLevel) qualCnt_reg <= '0;
         else if (qualCnt_reg < 32'(QUAL_CYCLES)) qualCnt_reg <= qualCnt_reg + 32'd1;
      end
   end

   // Edge of qualified level marks a new crossing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) qualified_reg <= 1'b0;
      else if (ce) qualified_reg <= qualified;
   end

   // Hold timer counted in tenths; a new crossing reloads it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         holdCnt_reg <= '0;
         tickCnt_reg <= '0;
      end else if (ce) begin
         if (qualified && !qualified_reg && hold != 10'd0) begin
            holdCnt_reg <= holdTicks;
            tickCnt_reg <= '0;
         end else if (holdCnt_reg != 16'd0) begin
            if (tickCnt_reg == 32'(TENTH_S_CYCLES - 1)) begin
               tickCnt_reg <= '0;
               holdCnt_reg <= holdCnt_reg - 16'd1;
            end else tickCnt_reg <= tickCnt_reg + 32'd1;
         end
      end
   end

   assign active = (hold == 10'd0) ? qualified : (holdCnt_reg != 16'd0);

   // Output stage registered, latency one cycle, well inside 15 ms
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) closed <= 1'b0;
      else if (ce) begin
         case (mode)
            MODE_DISABLED:      closed <= 1'b0;
            MODE_CLOSE_ON_TRIP: closed <= active;
            MODE_OPEN_ON_TRIP:  closed <= !active;
            MODE_REMOTE:        closed <= remoteState;
            default:            closed <= 1'b0;
         endcase
      end
   end
endmodule // relay_channel
`default_nettype wire

/* File: hdl/relay_ctrl.sv */
/*
 Threshold relay controller with APB register file.
 Assumes the counter front end supplies the scaled result and applies zeroing.
*/
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module relay_ctrl #(
   parameter int N = 4
) (
   // Clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     ce,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Counter interface
   input  wire logic signed [31:0]       result,
   input  wire logic                     zeroEvent,
   output logic                          zeroReq,
   output logic signed [31:0]            zeroValue,
   // Relays
   output logic      [N-1:0]             relayClosed,
   output logic      [N-1:0]             led
);
   import relay_ctrl_pkg::*;

   // Elaboration check: the remote holding word and the channel window serve at most eight relays
   if (N < 1 || N > 8) begin : gBadN
      $error("relay_ctrl: N must be 1..8");
   end

   relay_cfg_if #(.N(N)) cfgAct ();

   logic signed [31:0] levelW_reg [N];
   logic [2:0]         modeW_reg  [N];
   logic [9:0]         holdW_reg  [N];
   logic               autoZero_reg, batch_reg;
   logic signed [31:0] zeroW_reg;
   logic [N-1:0]       remote_reg;
   logic               zeroCmd_reg;
   logic               wrEn, rdEn, bad;
   logic               applyNow;

   // ===========================================================
   // APB decode
   function automatic logic isCh(input logic [11:0] a);
      isCh = (a >= ADDR_CH0) && (a < ADDR_CH0 + 12'(N) * CH_STRIDE);
   endfunction
   function automatic int chIdx(input logic [11:0] a);
      chIdx = int'((a - ADDR_CH0) >> 4);
   endfunction

   assign pready  = 1'b1;
   assign wrEn    = psel && penable && pwrite && ce;
   assign rdEn    = psel && !penable && !pwrite; // Setup cycle of a read
   assign bad     = !(isCh(paddr) || paddr == ADDR_CTRL || paddr == ADDR_ZERO
                      || paddr == ADDR_RESULT || paddr == ADDR_STATUS || paddr == ADDR_REMOTE);
   assign pslverr = psel && penable && bad;

   // ===========================================================
   // Written settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         autoZero_reg <= 1'b0;
         batch_reg    <= 1'b0;
         zeroW_reg    <= '0;
         zeroCmd_reg  <= 1'b0;
         for (int i = 0; i < N; i++) begin
            levelW_reg[i] <= '0;
            modeW_reg[i]  <= '0;
            holdW_reg[i]  <= '0;
         end
      end else if (ce) begin
         zeroCmd_reg <= 1'b0;
         if (wrEn) begin
            if (paddr == ADDR_CTRL) begin
               autoZero_reg <= pwdata[CTRL_AUTOZERO];
               batch_reg    <= pwdata[CTRL_BATCH];
               zeroCmd_reg  <= pwdata[CTRL_ZERO_CMD];
            end
            if (paddr == ADDR_ZERO) zeroW_reg <= pwdata;
            if (isCh(paddr)) begin
               case (paddr[3:0])
                  CH_LEVEL[3:0]: begin
                     if ($signed(pwdata) >= LEVEL_MIN && $signed(pwdata) <= LEVEL_MAX)
                        levelW_reg[chIdx(paddr)] <= pwdata;
                  end
                  CH_MODE[3:0]:  modeW_reg[chIdx(paddr)] <= pwdata[2:0];
                  CH_HOLD[3:0]: begin
                     if (pwdata <= 32'(HOLD_MAX)) holdW_reg[chIdx(paddr)] <= pwdata[9:0];
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // Remote holding bits: writes only land in remote mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) remote_reg <= '0;
      else if (ce && wrEn && paddr == ADDR_REMOTE) begin
         for (int i = 0; i < N; i++)
            if (relay_mode_e'(cfgAct.mode[i]) == MODE_REMOTE) remote_reg[i] <= pwdata[i];
      end
   end

   // ===========================================================
   // Active settings: immediate in counting mode, at zeroing in batching
   assign applyNow = !batch_reg || zeroEvent || zeroReq;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zeroValue <= '0;
         for (int i = 0; i < N; i++) begin
            cfgAct.level[i]   <= '0;
            cfgAct.hold[i]    <= '0;
         end
      end else if (ce && applyNow) begin
         zeroValue <= zeroW_reg;
         for (int i = 0; i < N; i++) begin
            cfgAct.level[i] <= levelW_reg[i];
            cfgAct.hold[i]  <= holdW_reg[i];
         end
      end
   end
   // Mode and unit are not scaling parameters and always apply at once
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cfgAct.mode[i]    = relay_mode_e'(modeW_reg[i][1:0]);
         cfgAct.unitMin[i] = modeW_reg[i][UNIT_BIT];
      end
   end

   // Self-zero request when first trip level is reached
   assign zeroReq = zeroCmd_reg || (autoZero_reg && result >= cfgAct.level[0]);

   // ===========================================================
   // Relay channels, evaluated in parallel
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gCh
         relay_channel #(.IMMEDIATE(g == 0)) uCh (
            .clk         (clk),
            .nrst        (nrst),
            .ce          (ce),
            .result      (result),
            .level       (cfgAct.level[g]),
            .allowed     (g == 0 || !autoZero_reg || cfgAct.level[g] <= cfgAct.level[0]),
            .hold        (cfgAct.hold[g]),
            .unitMin     (cfgAct.unitMin[g]),
            .mode        (cfgAct.mode[g]),
            .remoteState (remote_reg[g]),
            .closed      (relayClosed[g])
         );
      end
   endgenerate
   assign led = relayClosed;

   // ===========================================================
   // Read data, registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) prdata <= RST_WORD;
      else if (ce && rdEn) begin
         prdata <= RST_WORD;
         if (paddr == ADDR_CTRL) prdata <= {29'd0, 1'b0, batch_reg, autoZero_reg};
         if (paddr == ADDR_ZERO) prdata <= zeroW_reg;
         if (paddr == ADDR_RESULT) prdata <= result;
         if (paddr == ADDR_STATUS || paddr == ADDR_REMOTE) prdata <= 32'(relayClosed);
         if (isCh(paddr)) begin
            case (paddr[3:0])
               CH_LEVEL[3:0]: prdata <= levelW_reg[chIdx(paddr)];
               CH_MODE[3:0]:  prdata <= 32'(modeW_reg[chIdx(paddr)]);
               CH_HOLD[3:0]:  prdata <= 32'(holdW_reg[chIdx(paddr)]);
               default:       prdata <= RST_WORD;
            endcase
         end
      end
   end
endmodule // relay_ctrl
`default_nettype wire

/* File: pkg/relay_cfg_if.sv */
/*
 Shadow settings bus between the register file and the relay channels.
 Assumes both ends on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface relay_cfg_if #(parameter int N = 4);
   import relay_ctrl_pkg::*;
   logic signed [LEVEL_W-1:0] level [N];
   relay_mode_e               mode  [N];
   logic        [9:0]         hold  [N];
   logic                      unitMin [N];
   modport src (output level, output mode, output hold, output unitMin);
   modport dst (input level, input mode, input hold, input unitMin);
endinterface
`default_nettype wire

/* File: pkg/relay_ctrl_pkg.sv */
/*
 Constants, types and register map of the threshold relay controller.
 Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package relay_ctrl_pkg;
   // ===========================================================
   // Timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int QUAL_MS        = 20;
   localparam int QUAL_CYCLES    = CLK_HZ / 1000 * QUAL_MS;
   localparam int TENTH_S_CYCLES = CLK_HZ / 10;
   localparam int SEC_PER_MIN    = 60;
   localparam int HOLD_MAX       = 999;
   localparam int LEVEL_MIN      = -99999;
   localparam int LEVEL_MAX      = 999999;
   localparam int LEVEL_W        = 32;
   // ===========================================================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_ZERO   = 12'h004;
   localparam logic [11:0] ADDR_RESULT = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_REMOTE = 12'h010;
   localparam logic [11:0] ADDR_CH0    = 12'h100;
   localparam logic [11:0] CH_STRIDE   = 12'h010;
   localparam logic [11:0] CH_LEVEL    = 12'h000;
   localparam logic [11:0] CH_MODE     = 12'h004;
   localparam logic [11:0] CH_HOLD     = 12'h008;
   // Field positions
   localparam int CTRL_AUTOZERO = 0;
   localparam int CTRL_BATCH    = 1;
   localparam int CTRL_ZERO_CMD = 2;
   localparam int MODE_LSB      = 0;
   localparam int UNIT_BIT      = 2;
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // Polarity modes
   typedef enum logic [1:0] {MODE_DISABLED, MODE_CLOSE_ON_TRIP, MODE_OPEN_ON_TRIP, MODE_REMOTE} relay_mode_e;
endpackage

/* File: tb/counter_model.sv */
/* Counter front end model: holds the scaled result.
 Assumes zeroReq and zeroValue come from relay_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module counter_model (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               nrst,
   // Controller side
   input  wire logic               zeroReq,
   input  wire logic signed [31:0] zeroValue,
   output logic signed [31:0]      result,
   output logic                    zeroEvent,
   // Bench side
   input  wire logic               manualZero,
   input  wire logic               setEn,
   input  wire logic signed [31:0] setVal,
   input  wire logic               step
);
   // ==========================================
   // Zeroing wins over loads and counting
   assign zeroEvent = manualZero;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         result <= 32'sh0;
      else if (zeroReq || zeroEvent)
         result <= zeroValue;
      else if (setEn)
         result <= setVal;
      else if (step)
         result <= result + 32'sh1;
   end
endmodule // counter_model
`default_nettype wire

/* File: tb/relay_ctrl_chk.sv */
/* Checker on relay_ctrl ports, tracking channel 0 settings.
 Assumes it is bound onto relay_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module relay_ctrl_chk
   import relay_ctrl_pkg::*;
#(parameter int N = 4) (
   // Clock and reset
   input wire logic               clk,
   input wire logic               nrst,
   input wire logic               ce,
   // APB
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Counter and relays
   input wire logic signed [31:0] result,
   input wire logic               zeroEvent,
   input wire logic               zeroReq,
   input wire logic signed [31:0] zeroValue,
   input wire logic [N-1:0]       relayClosed,
   input wire logic [N-1:0]       led
);
   logic signed [31:0] lvlReg;
   logic [1:0]         modeReg;
   logic [9:0]         holdReg;
   logic               azReg;
   logic               batchReg;
   wire logic wr    = psel && penable && pwrite && ce;
   wire logic remWr = wr && paddr == ADDR_REMOTE;
   // Batching delays levels, so trip checks only run in counting mode
   wire logic trip  = !batchReg && ce && result >= lvlReg;
   wire logic below = !batchReg && ce && result < lvlReg;
   // ==========================================
   // Shadow of control settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         azReg <= 1'b0;
         batchReg <= 1'b0;
      end else if (wr && paddr == ADDR_CTRL) begin
         azReg <= pwdata[CTRL_AUTOZERO];
         batchReg <= pwdata[CTRL_BATCH];
      end
   end
   // Shadow of channel 0, refusing out of range values
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lvlReg <= 32'sh0;
         modeReg <= 2'h0;
         holdReg <= 10'h000;
      end else if (wr) begin
         if (paddr == ADDR_CH0 + CH_LEVEL && $signed(pwdata) >= LEVEL_MIN && $signed(pwdata) <= LEVEL_MAX)
            lvlReg <= pwdata;
         if (paddr == ADDR_CH0 + CH_MODE)
            modeReg <= pwdata[1:0];
         if (paddr == ADDR_CH0 + CH_HOLD && pwdata <= 32'(HOLD_MAX))
            holdReg <= pwdata[9:0];
      end
   end
   // ==========================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   led_match_a: assert property (led == relayClosed)
      else $error("LED differs from relay");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("Error flag outside access");
   reset_open_a: assert property ($rose(nrst) |-> relayClosed == '0)
      else $error("Relay closed after reset");
   auto_zero_a: assert property (azReg && trip |-> ##[0:1] zeroReq)
      else $error("No zeroing at first level");
   close_trip_a: assert property (modeReg == MODE_CLOSE_ON_TRIP && holdReg == 0 && trip |=> relayClosed[0])
      else $error("Relay not closed at level");
   close_idle_a: assert property (modeReg == MODE_CLOSE_ON_TRIP && holdReg == 0 && below |=> !relayClosed[0])
      else $error("Relay closed below level");
   open_trip_a: assert property (modeReg == MODE_OPEN_ON_TRIP && holdReg == 0 && trip |=> !relayClosed[0])
      else $error("Relay not opened at level");
   disabled_off_a: assert property (modeReg == MODE_DISABLED |=> !relayClosed[0])
      else $error("Disabled relay closed");
   remote_hold_a: assert property (modeReg == MODE_REMOTE && $stable(modeReg) && !remWr && !$past(remWr)
      |=> $stable(relayClosed[0]))
      else $error("Remote relay moved alone");
   cover property (zeroReq);
   cover property ($rose(relayClosed[0]));
   cover property (pslverr);
endmodule // relay_ctrl_chk
bind relay_ctrl relay_ctrl_chk #(.N(N)) chk_u (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .result(result), .zeroEvent(zeroEvent), .zeroReq(zeroReq),
   .zeroValue(zeroValue), .relayClosed(relayClosed), .led(led));
`default_nettype wire

/* File: tb/relay_ctrl_test.sv */
/* Bench for relay_ctrl over APB with a counter model.
 Assumes the package timers; qualification is never reached. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module relay_ctrl_test;
   import relay_ctrl_pkg::*;
   logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, err;
   logic zeroEvent, zeroReq, manualZero, setEn, step;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [31:0] result, zeroValue, setVal;
   logic [3:0] relayClosed, led;
   int miscompares, checked, i;
   localparam logic [11:0] LV0 = ADDR_CH0 + CH_LEVEL;
   localparam logic [11:0] MD0 = ADDR_CH0 + CH_MODE;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   relay_ctrl #(.N(4)) dut_u (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .result(result), .zeroEvent(zeroEvent), .zeroReq(zeroReq),
      .zeroValue(zeroValue), .relayClosed(relayClosed), .led(led));
   counter_model cnt_u (.clk(clk), .nrst(nrst), .zeroReq(zeroReq), .zeroValue(zeroValue),
      .result(result), .zeroEvent(zeroEvent), .manualZero(manualZero), .setEn(setEn),
      .setVal(setVal), .step(step));
   // ==========================================
   task close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         miscompares++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task setr(input logic [31:0] v);
      @(posedge clk);
      setVal <= v;
      setEn <= 1'b1;
      @(posedge clk);
      setEn <= 1'b0;
   endtask
   // Relay 1 is armed at level 0 but never qualifies in this short run
   task relay(input logic [3:0] e);
      repeat (3) @(posedge clk);
      @(negedge clk); // Sample away from the edge that launches the outputs
      `CHK(relayClosed, e)
      `CHK(led, e)
   endtask
   initial begin
      repeat (50000) @(posedge clk);
      miscompares++;
      close_out();
   end
   initial begin
      {nrst, psel, penable, pwrite, manualZero, setEn, step} = 7'h00;
      ce = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      setVal = 32'sh0;
      miscompares = 0;
      checked = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      relay(4'h0);
      rdchk(MD0, RST_WORD);
      $display("reset test done");
      wr(ADDR_CH0 + CH_STRIDE + CH_MODE, 32'h1);
      wr(LV0, 32'h64);
      wr(MD0, 32'h1);
      setr(32'h63); relay(4'h0);
      setr(32'h64); relay(4'h1);
      repeat (1000) @(posedge clk);
      relay(4'h1);
      wr(MD0, 32'h2); relay(4'h0);
      setr(32'h32); relay(4'h1);
      $display("polarity test done");
      wr(MD0, 32'h3); relay(4'h0);
      wr(ADDR_REMOTE, 32'h1); setr(32'hc8); relay(4'h1);
      rdchk(ADDR_REMOTE, 32'h1);
      wr(MD0, 32'h1); wr(ADDR_REMOTE, 32'h0); relay(4'h1);
      rdchk(ADDR_REMOTE, 32'h1);
      $display("remote test done");
      wr(LV0, 32'h000f_4240); rdchk(LV0, 32'h64);
      wr(LV0, 32'hfffe_7961); wr(LV0, 32'hfffe_7960); rdchk(LV0, 32'hfffe_7961);
      wr(ADDR_CH0 + CH_HOLD, 32'h3e8); rdchk(ADDR_CH0 + CH_HOLD, 32'h0);
      apb(1'b0, 12'hffc, 32'h0); `CHK(err, 1'b1)
      $display("range test done");
      wr(ADDR_ZERO, 32'h5);
      wr(LV0, 32'h64); setr(32'h96); relay(4'h1);
      wr(ADDR_CTRL, 32'h2); wr(LV0, 32'hc8); relay(4'h1);
      @(posedge clk); manualZero <= 1'b1;
      @(posedge clk); manualZero <= 1'b0;
      setr(32'h96); relay(4'h0);
      $display("batch test done");
      wr(ADDR_CTRL, 32'h0); wr(ADDR_CH0 + CH_HOLD, 32'h1);
      setr(32'hc8); relay(4'h1);
      setr(32'h0); relay(4'h1);
      $display("hold test done");
      wr(MD0, 32'h0); wr(ADDR_CH0 + CH_HOLD, 32'h0); relay(4'h0);
      wr(ADDR_CTRL, 32'h1); setr(32'hbe);
      @(posedge clk); step <= 1'b1;
      for (i = 0; i < 64 && zeroReq !== 1'b1; i++) @(posedge clk);
      step <= 1'b0;
      `CHK(i < 64, 1'b1)
      repeat (2) @(posedge clk);
      `CHK(result, 32'sh5)
      $display("autozero test done");
      close_out();
   end
endmodule // relay_ctrl_test
`default_nettype wire
